// ===== sim/sbpg_bus_model.sv
`timescale 1ns/1ps
module sbpg_bus_model (
   input  wire logic       scl_o_i,        // Block clock level
   input  wire logic       scl_oe_i,       // Block clock enable
   input  wire logic       sda_o_i,        // Block data level
   input  wire logic       sda_oe_i,       // Block data enable
   input  wire logic [1:0] ext_low_i,      // Outside pulls low, bit 1 data
   input  wire logic [1:0] eng_req_i,      // Engine wants low, bit 1 data
   input  wire logic       eng_rst_i,      // Engine in reset
   output logic            scl_line_o,     // Clock wire
   output logic            sda_line_o,     // Data wire
   output logic            eng_scl_pull_o, // Engine clock pull
   output logic            eng_sda_pull_o  // Engine data pull
);
   // Pull-ups hold released wires high; any low wins, as on a wired-and line
   assign scl_line_o = (scl_oe_i ? scl_o_i : 1'b1) & ~ext_low_i[0];
   assign sda_line_o = (sda_oe_i ? sda_o_i : 1'b1) & ~ext_low_i[1];
   // An engine held in reset never pulls a line
   assign eng_scl_pull_o = eng_req_i[0] & ~eng_rst_i;
   assign eng_sda_pull_o = eng_req_i[1] & ~eng_rst_i;
endmodule : sbpg_bus_model

// ===== sim/sbpg_gpio_asserts.sv
`timescale 1ns/1ps
`include "sbpg_defs.svh"
module sbpg_gpio_chk (
   input wire logic                 clk_sys_i,      // Clock
   input wire logic                 rst_i,          // Reset
   input wire logic                 ce_i,           // Enable
   input wire logic                 psel_i,         // Select
   input wire logic                 penable_i,      // Access
   input wire logic                 pwrite_i,       // Write
   input wire sbpg_pkg::sbpg_addr_t paddr_i,        // Address
   input wire sbpg_pkg::sbpg_word_t pwdata_i,       // Write data
   input wire sbpg_pkg::sbpg_word_t prdata_o,       // Read data
   input wire logic                 pready_o,       // Ready
   input wire logic                 pslverr_o,      // Error
   input wire logic                 scl_pin_i,      // Clock pin in
   input wire logic                 scl_pin_o,      // Clock pin out
   input wire logic                 scl_pin_oe_o,   // Clock pin enable
   input wire logic                 sda_pin_i,      // Data pin in
   input wire logic                 sda_pin_o,      // Data pin out
   input wire logic                 sda_pin_oe_o,   // Data pin enable
   input wire logic                 eng_scl_pull_i, // Engine clock pull
   input wire logic                 eng_scl_o,      // Engine clock
   input wire logic                 eng_sda_o,      // Engine data
   input wire logic                 eng_rst_o,      // Engine reset
   input wire logic                 gpio_mode_o     // GPIO mode
);
   import sbpg_pkg::*;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   // Completed transfers and their targets
   wire done_w    = psel_i & penable_i & pready_o;
   wire rd_w      = done_w & ~pwrite_i;
   wire wr_func_w = done_w & pwrite_i & (paddr_i == `SBPG_OFS_FUNC);
   wire wr_mode_w = done_w & pwrite_i & (paddr_i == `SBPG_OFS_MODE);
   wire mapped_w  = paddr_i inside {12'h000, 12'h004, 12'h008, 12'h00c, 12'h010};
   logic [1:0] mode_hist;
   logic [1:0] pins_q;
   logic [3:0] still_q;
   // Mode must hold a few cycles before outputs are judged, as they lag the register
   wire bus_ok  = ~gpio_mode_o & (&mode_hist);
   wire gpio_ok = gpio_mode_o & ~(|mode_hist);
   // Pin history; the count saturates so it never wraps to a false zero
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         mode_hist <= 2'h3;
         pins_q    <= 2'h3;
         still_q   <= 4'h0;
      end else begin
         mode_hist <= {mode_hist[0], ~gpio_mode_o};
         pins_q    <= {sda_pin_i, scl_pin_i};
         still_q   <= ({sda_pin_i, scl_pin_i} != pins_q) ? 4'h0 : still_q + {3'h0, still_q != 4'hf};
      end
   end
   ready_wait_a: assert property (psel_i && penable_i && !pready_o && ce_i |=> pready_o)
      else $error("no ready after access");
   ready_pulse_a: assert property (pready_o |=> !pready_o) else $error("ready held");
   err_unmapped_a: assert property (done_w |-> pslverr_o == !mapped_w) else $error("bad error flag");
   resv_zero_a: assert property (rd_w && mapped_w |-> prdata_o[31:2] == 30'h0)
      else $error("reserved bits set");
   func_write_a: assert property (wr_func_w && pwdata_i[0] |-> ##[1:2] gpio_mode_o)
      else $error("mode not entered");
   eng_reset_a: assert property (wr_mode_w |-> ##2 eng_rst_o == !$past(pwdata_i[0], 2))
      else $error("engine reset wrong");
   gpio_quiet_a: assert property (gpio_ok |-> eng_scl_o && eng_sda_o)
      else $error("engine sees pins");
   bus_level_a: assert property (bus_ok |-> !scl_pin_o && !sda_pin_o)
      else $error("driven level in bus mode");
   reset_quiet_a: assert property (bus_ok && eng_rst_o && $past(eng_rst_o) |-> !scl_pin_oe_o && !sda_pin_oe_o)
      else $error("driving while engine reset");
   eng_drive_a: assert property (bus_ok && !eng_rst_o && !$past(eng_rst_o) && $past(eng_scl_pull_i)
      |-> scl_pin_oe_o && !scl_pin_o) else $error("engine pull lost");
   level_read_a: assert property (rd_w && paddr_i == `SBPG_OFS_LEVEL && still_q[3]
      |-> prdata_o[1:0] == {sda_pin_i, scl_pin_i}) else $error("level mismatch");
   gpio_seen_c: cover property (wr_func_w && pwdata_i[0]);
   unmapped_c: cover property (done_w && pslverr_o);
   eng_drive_c: cover property (bus_ok && scl_pin_oe_o);
endmodule : sbpg_gpio_chk

bind sbpg_gpio sbpg_gpio_chk chk_u (.clk_sys_i, .rst_i, .ce_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
   .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .scl_pin_i, .scl_pin_o, .scl_pin_oe_o, .sda_pin_i,
   .sda_pin_o, .sda_pin_oe_o, .eng_scl_pull_i, .eng_scl_o, .eng_sda_o, .eng_rst_o, .gpio_mode_o);

// ===== sim/test_serial_bus_pin_gpio_fallback.sv
`timescale 1ns/1ps
`include "sbpg_defs.svh"
module test_serial_bus_pin_gpio_fallback;
   import sbpg_pkg::*;
   logic       clk_sys_i, rst_i, ce, psel, penable, pwrite, pready, pslverr;
   logic       scl_line, sda_line, scl_o, scl_oe, sda_o, sda_oe;
   logic       eng_scl_pull, eng_sda_pull, eng_scl, eng_sda, eng_rst, gpio_mode;
   logic [1:0] ext_low, eng_req;
   sbpg_addr_t paddr;
   sbpg_word_t pwdata, prdata;
   int         err_total, checked;
   sbpg_gpio dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .scl_pin_i(scl_line), .scl_pin_o(scl_o), .scl_pin_oe_o(scl_oe),
      .sda_pin_i(sda_line), .sda_pin_o(sda_o), .sda_pin_oe_o(sda_oe), .eng_scl_pull_i(eng_scl_pull),
      .eng_sda_pull_i(eng_sda_pull), .eng_scl_o(eng_scl), .eng_sda_o(eng_sda), .eng_rst_o(eng_rst),
      .gpio_mode_o(gpio_mode));
   sbpg_bus_model model_u (.scl_o_i(scl_o), .scl_oe_i(scl_oe), .sda_o_i(sda_o), .sda_oe_i(sda_oe),
      .ext_low_i(ext_low), .eng_req_i(eng_req), .eng_rst_i(eng_rst), .scl_line_o(scl_line),
      .sda_line_o(sda_line), .eng_scl_pull_o(eng_scl_pull), .eng_sda_pull_o(eng_sda_pull));
   task automatic chk(input sbpg_word_t got, input sbpg_word_t exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // One APB transfer; the request holds until ready is sampled high
   task automatic apb(input logic wr, input sbpg_addr_t a, input sbpg_word_t d, output sbpg_word_t q,
                      output logic e);
      @(posedge clk_sys_i);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_sys_i);
      penable <= 1'b1;
      @(posedge clk_sys_i);
      while (pready !== 1'b1) @(posedge clk_sys_i);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input sbpg_addr_t a, input sbpg_word_t d);
      sbpg_word_t q;
      logic       e;
      apb(1'b1, a, d, q, e);
      chk(32'(e), 32'h0);
   endtask : wr
   task automatic rd(input sbpg_addr_t a, input sbpg_word_t exp);
      sbpg_word_t q;
      logic       e;
      apb(1'b0, a, 32'h0, q, e);
      chk(q, exp);
   endtask : rd
   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask : idle
   task automatic sc_reset;
      rd(`SBPG_OFS_FUNC, 32'h0);
      rd(`SBPG_OFS_DIR, 32'h0);
      chk(32'(eng_rst), 32'h1);
   endtask : sc_reset
   task automatic sc_reserved;
      sbpg_word_t q;
      logic       e;
      wr(`SBPG_OFS_FUNC, 32'hffff_fffe);
      rd(`SBPG_OFS_FUNC, 32'h0);
      wr(`SBPG_OFS_DIR, 32'hffff_fffc);
      rd(`SBPG_OFS_DIR, 32'h0);
      wr(`SBPG_OFS_LEVEL, 32'hffff_ffff);
      rd(`SBPG_OFS_FUNC, 32'h0);
      rd(`SBPG_OFS_LEVEL, 32'h3);
      apb(1'b0, 12'h014, 32'h0, q, e);
      chk(32'(e), 32'h1);
      chk(q, 32'h0);
   endtask : sc_reserved
   // Clock enable low freezes the engine view; it catches up once enabled
   task automatic sc_freeze;
      ce      <= 1'b0;
      ext_low <= 2'h3;
      idle(8);
      chk({30'h0, eng_sda, eng_scl}, 32'h3);
      ce <= 1'b1;
      idle(7);
      chk({30'h0, eng_sda, eng_scl}, 32'h0);
      ext_low <= 2'h0;
      idle(7);
   endtask : sc_freeze
   task automatic sc_gpio;
      wr(`SBPG_OFS_MODE, 32'h0);
      wr(`SBPG_OFS_FUNC, 32'h1);
      wr(`SBPG_OFS_OUTVAL, 32'h2);
      ext_low <= 2'h3;
      for (int i = 0; i < 4; i++) begin
         wr(`SBPG_OFS_DIR, 32'(i));
         idle(2);
         chk({30'h0, sda_oe, scl_oe}, 32'(i));
      end
      chk({30'h0, sda_o, scl_o}, 32'h2);
      idle(6);
      chk({30'h0, eng_sda, eng_scl}, 32'h3);
      rd(`SBPG_OFS_FUNC, 32'h1);
      chk(32'(gpio_mode), 32'h1);
      rd(`SBPG_OFS_DIR, 32'h3);
      ext_low <= 2'h0;
      wr(`SBPG_OFS_OUTVAL, 32'h1);
      idle(6);
      rd(`SBPG_OFS_LEVEL, 32'h1);
      wr(`SBPG_OFS_FUNC, 32'h0);
      idle(2);
      chk({30'h0, sda_oe, scl_oe}, 32'h0);
      wr(`SBPG_OFS_DIR, 32'h0);
   endtask : sc_gpio
   task automatic sc_levels;
      for (int m = 0; m < 2; m++) begin
         wr(`SBPG_OFS_FUNC, 32'(m));
         for (int i = 0; i < 4; i++) begin
            ext_low <= 2'(3 - i);
            idle(6);
            rd(`SBPG_OFS_LEVEL, 32'(i));
            chk({30'h0, eng_sda, eng_scl}, (m == 1) ? 32'h3 : 32'(i));
         end
      end
      ext_low <= 2'h0;
   endtask : sc_levels
   task automatic sc_engine;
      wr(`SBPG_OFS_FUNC, 32'h0);
      eng_req <= 2'h3;
      wr(`SBPG_OFS_MODE, 32'h1);
      idle(3);
      chk({28'h0, eng_rst, scl_oe, sda_oe, sda_o}, 32'h6);
      idle(6);
      rd(`SBPG_OFS_LEVEL, 32'h0);
      eng_req <= 2'h0;
      wr(`SBPG_OFS_FUNC, 32'h1);
      idle(6);
      chk({29'h0, eng_rst, eng_sda, eng_scl}, 32'h3);
      rd(`SBPG_OFS_MODE, 32'h1);
      wr(`SBPG_OFS_MODE, 32'h0);
      idle(2);
      chk(32'(eng_rst), 32'h1);
   endtask : sc_engine
   task automatic conclude;
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : conclude
   // Free-running 100 MHz clock
   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   // Whole run needs well under 2000 cycles
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      err_total++;
      conclude();
   end
   initial begin
      {rst_i, ce, psel, penable, pwrite, paddr, pwdata, ext_low, eng_req} <= {2'b11, 51'h0};
      err_total = 0;
      checked   = 0;
      repeat (4) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      sc_reset();
      sc_reserved();
      sc_freeze();
      sc_gpio();
      sc_levels();
      sc_engine();
      conclude();
   end
endmodule : test_serial_bus_pin_gpio_fallback

// ===== verilog/sbpg_defs.svh
`ifndef SBPG_DEFS_SVH
`define SBPG_DEFS_SVH

// Register byte offsets
`define SBPG_OFS_FUNC       12'h000
`define SBPG_OFS_DIR        12'h004
`define SBPG_OFS_LEVEL      12'h008
`define SBPG_OFS_OUTVAL     12'h00c
`define SBPG_OFS_MODE       12'h010

// Field positions
`define SBPG_BIT_GPIO_MODE  0
`define SBPG_BIT_CLK_PIN    0
`define SBPG_BIT_DATA_PIN   1
`define SBPG_BIT_ENG_RUN    0

// Reset values
`define SBPG_RST_FUNC       1'b0
`define SBPG_RST_DIR        2'b00
`define SBPG_RST_OUTVAL     2'b00
`define SBPG_RST_ENG_RUN    1'b0
`define SBPG_RST_PIN_LEVEL  2'b11
`define SBPG_RST_PIN_BIT    1'b1
`define SBPG_RST_RDATA      32'h0000_0000

// Address decode width and pin count
`define SBPG_ADDR_W         12
`define SBPG_PIN_N          2

`endif

// ===== verilog/sbpg_gpio.sv
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "sbpg_defs.svh"

module sbpg_gpio (
   // System side
   input  wire logic                clk_sys_i,      // System clock, 100 MHz
   input  wire logic                rst_i,          // Async reset, active high
   input  wire logic                ce_i,           // Clock enable, freezes all state when low
   // APB slave
   input  wire logic                psel_i,         // Slave select
   input  wire logic                penable_i,      // Access phase
   input  wire logic                pwrite_i,       // Write when high
   input  wire sbpg_pkg::sbpg_addr_t paddr_i,       // Byte address
   input  wire sbpg_pkg::sbpg_word_t pwdata_i,      // Write data
   output sbpg_pkg::sbpg_word_t      prdata_o,     // Read data
   output logic                     pready_o,       // Transfer done
   output logic                     pslverr_o,      // Unmapped address
   // Serial clock pin
   input  wire logic                scl_pin_i,      // Clock pin level from input buffer
   output logic                     scl_pin_o,      // Clock pin drive level
   output logic                     scl_pin_oe_o,   // Clock pin drive enable
   // Serial data pin
   input  wire logic                sda_pin_i,      // Data pin level from input buffer
   output logic                     sda_pin_o,      // Data pin drive level
   output logic                     sda_pin_oe_o,   // Data pin drive enable
   // Protocol engine side
   input  wire logic                eng_scl_pull_i, // Engine pulls clock line low
   input  wire logic                eng_sda_pull_i, // Engine pulls data line low
   output logic                     eng_scl_o,      // Clock level seen by engine
   output logic                     eng_sda_o,      // Data level seen by engine
   output logic                     eng_rst_o,      // Engine held in reset
   // Status
   output logic                     gpio_mode_o     // Pins are general-purpose I/O
);
   import sbpg_pkg::*;

   // Register map; every register is one aligned word and unused bits read zero
   //   function select  bit 0 set makes both pins GPIO
   //   direction        bit 1 data pin, bit 0 clock pin; set means output
   //   pin level        bit 1 data pin, bit 0 clock pin; read only
   //   output value     bit 1 data pin, bit 0 clock pin; driven only as GPIO output
   //   mode             bit 0 set lets the protocol engine run
   // Unmapped offsets answer with an error and read zero.

   // ------------------------------------------------------------------
   // Control state
   // ------------------------------------------------------------------
   logic       gpio_mode_select;     // Function select
   sbpg_pins_t pin_direction;        // Bit 1 data pin, bit 0 clock pin
   sbpg_pins_t pin_output_value;     // Levels driven in GPIO output mode
   logic       engine_reset_release; // Engine runs while high

   // Settled pin levels after the synchroniser
   sbpg_pins_t pin_level;
   sbpg_pins_t raw_pins;

   // ------------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------------
   // Used for both the write strobes and the read mux
   function automatic sbpg_reg_t decode_reg(input sbpg_addr_t addr);
      sbpg_reg_t r;
      r = SBPG_REG_NONE;
      unique case (addr)
         `SBPG_OFS_FUNC:   r = SBPG_REG_FUNC;
         `SBPG_OFS_DIR:    r = SBPG_REG_DIR;
         `SBPG_OFS_LEVEL:  r = SBPG_REG_LEVEL;
         `SBPG_OFS_OUTVAL: r = SBPG_REG_OUTVAL;
         `SBPG_OFS_MODE:   r = SBPG_REG_MODE;
         default:          r = SBPG_REG_NONE;
      endcase
      return r;
   endfunction : decode_reg

   // Builds a read word with only the low pin bits live
   function automatic sbpg_word_t pin_word(input sbpg_pins_t bits);
      sbpg_word_t w;
      w = `SBPG_RST_RDATA;
      w[`SBPG_PIN_N-1:0] = bits;
      return w;
   endfunction : pin_word

   // ------------------------------------------------------------------
   // APB handshake
   // ------------------------------------------------------------------
   // Access phase waits one cycle so read data can come from a flop
   // Cost: every transfer takes one wait state, writes included
   wire        access_phase = psel_i & penable_i;
   wire        access_start = access_phase & ~pready_o;
   wire        access_done  = access_phase & pready_o;
   wire        wr_commit    = access_done & pwrite_i;
   wire        next_pready  = access_start;
   sbpg_reg_t  addr_reg;
   assign addr_reg = decode_reg(paddr_i);
   wire        addr_bad     = (addr_reg == SBPG_REG_NONE);

   // Write strobes, taken at the edge where pready is seen high
   wire        wr_func   = wr_commit & (addr_reg == SBPG_REG_FUNC);
   wire        wr_dir    = wr_commit & (addr_reg == SBPG_REG_DIR);
   wire        wr_outval = wr_commit & (addr_reg == SBPG_REG_OUTVAL);
   wire        wr_mode   = wr_commit & (addr_reg == SBPG_REG_MODE);
   // The pin-level register has no strobe at all, so a write there is dropped

   // ------------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------------
   sbpg_word_t rd_word;
   sbpg_pins_t func_bits;
   sbpg_pins_t mode_bits;

   // Single-bit registers widened with zero upper bits
   assign func_bits = {1'b0, gpio_mode_select};
   assign mode_bits = {1'b0, engine_reset_release};

   always_comb begin
      rd_word = `SBPG_RST_RDATA;
      unique case (addr_reg)
         SBPG_REG_FUNC:   rd_word = pin_word(func_bits);
         SBPG_REG_DIR:    rd_word = pin_word(pin_direction);
         SBPG_REG_LEVEL:  rd_word = pin_word(pin_level);
         SBPG_REG_OUTVAL: rd_word = pin_word(pin_output_value);
         SBPG_REG_MODE:   rd_word = pin_word(mode_bits);
         SBPG_REG_NONE:   rd_word = `SBPG_RST_RDATA;
      endcase
   end

   wire        rd_load   = next_pready & ~pwrite_i;
   wire        err_load  = next_pready & addr_bad;

   // Handshake answer; pready is a one-cycle pulse, but a held access sees it again every second cycle
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
      end else if (ce_i) begin
         pready_o  <= next_pready;
         pslverr_o <= err_load;
      end
   end

   // Read data changes only when a read is answered, then holds
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         prdata_o <= `SBPG_RST_RDATA;
      end else if (ce_i) begin
         if (rd_load) begin
            prdata_o <= rd_word;
         end
      end
   end

   // ------------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------------
   // Function select; only bit 0 is stored, upper write data is discarded
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         gpio_mode_select <= `SBPG_RST_FUNC;
      end else if (ce_i) begin
         if (wr_func) begin
            gpio_mode_select <= pwdata_i[`SBPG_BIT_GPIO_MODE];
         end
      end
   end

   // Direction bits; they only matter once GPIO mode is selected
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         pin_direction <= `SBPG_RST_DIR;
      end else if (ce_i) begin
         if (wr_dir) begin
            pin_direction <= pwdata_i[`SBPG_PIN_N-1:0];
         end
      end
   end

   // Output value is kept in bus mode too, so it is ready when GPIO mode returns
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         pin_output_value <= `SBPG_RST_OUTVAL;
      end else if (ce_i) begin
         if (wr_outval) begin
            pin_output_value <= pwdata_i[`SBPG_PIN_N-1:0];
         end
      end
   end

   // Engine run bit, untouched by function or direction writes
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         engine_reset_release <= `SBPG_RST_ENG_RUN;
      end else if (ce_i) begin
         if (wr_mode) begin
            engine_reset_release <= pwdata_i[`SBPG_BIT_ENG_RUN];
         end
      end
   end

   // ------------------------------------------------------------------
   // Pin input synchroniser
   // ------------------------------------------------------------------
   assign raw_pins[`SBPG_BIT_DATA_PIN] = sda_pin_i;
   assign raw_pins[`SBPG_BIT_CLK_PIN]  = scl_pin_i;

   // Levels are read whatever the function and direction settings are
   // In bus mode the engine reads the same settled levels, one cycle later
   sbpg_sync u_sync (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .ce_i      (ce_i),
      .pin_i     (raw_pins),
      .level_o   (pin_level)
   );

   // ------------------------------------------------------------------
   // Pin drive selection
   // ------------------------------------------------------------------
   // Drive per pin:
   //   GPIO, direction 1  drives its output-value bit
   //   GPIO, direction 0  released, the pin is an input only
   //   bus function       open drain, low while the engine pulls and runs
   // GPIO drive needs both the mode and the pin's own direction bit
   sbpg_pins_t gpio_drive_en;
   sbpg_pins_t eng_pull;
   sbpg_pins_t next_pin_oe;
   sbpg_pins_t next_pin_val;

   assign eng_pull[`SBPG_BIT_DATA_PIN] = eng_sda_pull_i;
   assign eng_pull[`SBPG_BIT_CLK_PIN]  = eng_scl_pull_i;

   genvar p;
   generate
      for (p = 0; p < `SBPG_PIN_N; p++) begin : g_drive
         assign gpio_drive_en[p] = gpio_mode_select & pin_direction[p];
         // Serial-bus function is open drain: the engine only ever pulls low
         assign next_pin_oe[p]   = gpio_mode_select ? gpio_drive_en[p]
                                                    : eng_pull[p] & ~eng_rst_o;
         assign next_pin_val[p]  = gpio_mode_select & pin_output_value[p];
      end
   endgenerate

   // ------------------------------------------------------------------
   // Engine side selection
   // ------------------------------------------------------------------
   // In GPIO mode the engine is fed idle-high lines so it never sees a bus event
   sbpg_pins_t next_eng_in;
   assign next_eng_in = gpio_mode_select ? `SBPG_RST_PIN_LEVEL : pin_level;

   // Engine reset follows the run bit only; the function select plays no part
   wire        next_eng_rst = ~engine_reset_release;

   // Clock pin drive; registered so the pad never sees decode glitches
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         scl_pin_o    <= 1'b0;
         scl_pin_oe_o <= 1'b0;
      end else if (ce_i) begin
         scl_pin_o    <= next_pin_val[`SBPG_BIT_CLK_PIN];
         scl_pin_oe_o <= next_pin_oe[`SBPG_BIT_CLK_PIN];
      end
   end

   // Data pin drive; one cycle behind the control bits, like the clock pin
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         sda_pin_o    <= 1'b0;
         sda_pin_oe_o <= 1'b0;
      end else if (ce_i) begin
         sda_pin_o    <= next_pin_val[`SBPG_BIT_DATA_PIN];
         sda_pin_oe_o <= next_pin_oe[`SBPG_BIT_DATA_PIN];
      end
   end

   // Engine view; idle-high lines and engine held in reset from power-up
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         eng_scl_o <= 1'b1;
         eng_sda_o <= 1'b1;
         eng_rst_o <= 1'b1;
      end else if (ce_i) begin
         eng_scl_o <= next_eng_in[`SBPG_BIT_CLK_PIN];
         eng_sda_o <= next_eng_in[`SBPG_BIT_DATA_PIN];
         eng_rst_o <= next_eng_rst;
      end
   end

   // Status copy of the function select
   always_ff @(posedge clk_sys_i or posedge rst_i) begin
      if (rst_i) begin
         gpio_mode_o <= `SBPG_RST_FUNC;
      end else if (ce_i) begin
         gpio_mode_o <= gpio_mode_select;
      end
   end

   // No interlock: switching modes with the engine running is left to software
   // A running engine sees idle-high lines in GPIO mode and simply waits

endmodule : sbpg_gpio

// ===== verilog/sbpg_pkg.sv
`include "sbpg_defs.svh"

package sbpg_pkg;

   // One bit per pin: bit 1 data line, bit 0 clock line
   typedef logic [`SBPG_PIN_N-1:0] sbpg_pins_t;

   // APB address as decoded by the block
   typedef logic [`SBPG_ADDR_W-1:0] sbpg_addr_t;

   // APB data word
   typedef logic [31:0] sbpg_word_t;

   // Registers the block decodes
   typedef enum logic [2:0] {
      SBPG_REG_FUNC,
      SBPG_REG_DIR,
      SBPG_REG_LEVEL,
      SBPG_REG_OUTVAL,
      SBPG_REG_MODE,
      SBPG_REG_NONE
   } sbpg_reg_t;

endpackage : sbpg_pkg

// ===== verilog/sbpg_sync.sv
`timescale 1ns/1ps
`include "sbpg_defs.svh"

module sbpg_sync (
   input  wire logic              clk_sys_i,   // System clock
   input  wire logic              rst_i,       // Async reset, active high
   input  wire logic              ce_i,        // Clock enable
   input  wire sbpg_pkg::sbpg_pins_t pin_i,    // Raw pin levels
   output sbpg_pkg::sbpg_pins_t      level_o   // Settled pin levels
);
   import sbpg_pkg::*;

   // One three-stage chain per pin; a change counts once stages two and three agree
   genvar g;
   generate
      for (g = 0; g < `SBPG_PIN_N; g++) begin : g_pin
         logic meta;
         logic stage2;
         logic stage3;
         wire  agree = (stage2 == stage3);

         // Stage one feeds stage two only, so metastability never reaches logic
         always_ff @(posedge clk_sys_i or posedge rst_i) begin
            if (rst_i) begin
               meta     <= `SBPG_RST_PIN_BIT;  // Idle-high lines, so release shows no false edge
               stage2   <= `SBPG_RST_PIN_BIT;
               stage3   <= `SBPG_RST_PIN_BIT;
               level_o[g] <= `SBPG_RST_PIN_BIT;
            end else if (ce_i) begin
               meta     <= pin_i[g];
               stage2   <= meta;
               stage3   <= stage2;
               if (agree) begin
                  level_o[g] <= stage3;
               end
            end
         end
      end
   endgenerate

endmodule : sbpg_sync
